// ### clock_gate_cells.sv
// Constants package for the peripheral clock gate bank and its enable-register cell
`timescale 1ns/1ps

package clock_gate_pkg;

    // Register bus geometry
    localparam int unsigned ADDR_W    = 12;
    localparam int unsigned DATA_W    = 32;

    // Register byte addresses
    localparam logic [11:0] OFF_SERIAL_AND_BUS = 12'h000;
    localparam logic [11:0] OFF_PORT_AND_TIMER = 12'h004;

    // Field positions in serial_and_bus_clock_gates
    localparam int unsigned SERIAL_LSB   = 10;  // Bits 12..10, port 2 down to 0
    localparam int unsigned SERIAL_W     = 3;
    localparam int unsigned TWO_WIRE_LSB = 6;   // Bits 7..6, bus 1 down to 0
    localparam int unsigned TWO_WIRE_W   = 2;

    // Field positions in port_and_timer_clock_gates
    localparam int unsigned PIN_PORT_LSB = 9;   // Bits 13..9, port E down to A
    localparam int unsigned PIN_PORT_W   = 5;
    localparam int unsigned TIMER_BIT    = 0;

    // Reserved fields that always read as one
    localparam logic [31:0] ONES_SERIAL_AND_BUS = 32'h0000_0030;
    localparam logic [31:0] ONES_PORT_AND_TIMER = 32'h0000_0180;

    // Gate enables carried together
    typedef struct packed {
        logic [SERIAL_W-1:0]   serial_port;   // [2] port 2 .. [0] port 0
        logic [TWO_WIRE_W-1:0] two_wire_bus;  // [1] bus 1 .. [0] bus 0
        logic [PIN_PORT_W-1:0] pin_port;      // [4] port E .. [0] port A
        logic                  timer_access;
    } gates_t;

    localparam int unsigned GATES_W     = $bits(gates_t);
    localparam gates_t      GATES_RESET = '0;  // All clocks stopped, timer locked

endpackage

////////////////////////////////////////////////////////////////////////////////

// Bank of enable flops that feed the downstream clock gates
module clock_enable_cells #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             reset_in,
    input  wire logic [WIDTH-1:0] enable_in,
    output logic      [WIDTH-1:0] enable_out
);

    logic [WIDTH-1:0] enable_d;
    logic [WIDTH-1:0] enable_q;

    // Enables only move at a rising edge, so a low-phase latch gate never chops a pulse
    always_comb begin
        enable_d = enable_in;
    end

    // Register the enables
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            enable_q <= '0;
        end else begin
            enable_q <= enable_d;
        end
    end

    assign enable_out = enable_q;

endmodule

// ### peripheral_clock_gate_bank.sv
// Peripheral clock gate bank: two gating registers behind an APB slave
//
// Our own choices: register access over APB and the register addresses.

`timescale 1ns/1ps

module peripheral_clock_gate_bank (
    input  wire logic                 CLK_IN,
    input  wire logic                 RESET_IN,
    input  wire logic                 PSEL_IN,
    input  wire logic                 PENABLE_IN,
    input  wire logic                 PWRITE_IN,
    input  wire logic [11:0]          PADDR_IN,
    input  wire logic [31:0]          PWDATA_IN,
    output logic                      PREADY_OUT,
    output logic      [31:0]          PRDATA_OUT,
    output logic                      PSLVERR_OUT,
    output clock_gate_pkg::gates_t    GATES_OUT
);

    ////////////////////////////////////////////////////////////////////////////
    // Register image functions

    // Read image of either register for a given address
    function automatic logic [31:0] read_image(
        input logic [11:0]            addr,
        input clock_gate_pkg::gates_t g
    );
        logic [31:0] w;
        w = '0;
        if (addr == clock_gate_pkg::OFF_SERIAL_AND_BUS) begin
            w = clock_gate_pkg::ONES_SERIAL_AND_BUS;
            w[clock_gate_pkg::SERIAL_LSB +: clock_gate_pkg::SERIAL_W]     = g.serial_port;
            w[clock_gate_pkg::TWO_WIRE_LSB +: clock_gate_pkg::TWO_WIRE_W] = g.two_wire_bus;
        end else if (addr == clock_gate_pkg::OFF_PORT_AND_TIMER) begin
            w = clock_gate_pkg::ONES_PORT_AND_TIMER;
            w[clock_gate_pkg::PIN_PORT_LSB +: clock_gate_pkg::PIN_PORT_W] = g.pin_port;
            w[clock_gate_pkg::TIMER_BIT] = g.timer_access;
        end
        return w;  // Every other bit stays zero
    endfunction

    // Address decode shared by the bus slave and the checks
    function automatic logic is_mapped(input logic [11:0] addr);
        return (addr == clock_gate_pkg::OFF_SERIAL_AND_BUS) ||
               (addr == clock_gate_pkg::OFF_PORT_AND_TIMER);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave state

    localparam int unsigned GW = clock_gate_pkg::GATES_W;

    logic                   pready_d;
    logic                   pready_q;
    logic [31:0]            prdata_d;
    logic [31:0]            prdata_q;
    logic                   pslverr_d;
    logic                   pslverr_q;
    clock_gate_pkg::gates_t gates_d;
    clock_gate_pkg::gates_t gates_q;
    logic                   access_wait;
    logic                   access_done;
    logic                   write_done;
    logic [GW-1:0]          enables_out;

    // Every transfer takes one wait state: the first access cycle only loads the answer
    // registers, and ready, data and error then stand for exactly one cycle.
    // A write lands on the edge that samples ready, so a refused write never reaches
    // the gate image.
    // First access cycle waits, the second completes with pready
    assign access_wait = PSEL_IN && PENABLE_IN && !pready_q;
    assign access_done = PSEL_IN && PENABLE_IN && pready_q;
    assign write_done  = access_done && PWRITE_IN && !pslverr_q;

    // Answer: ready, read data and error for the wait cycle
    always_comb begin
        pready_d  = access_wait;
        pslverr_d = access_wait && !is_mapped(PADDR_IN);  // Unmapped address answers with error
        prdata_d  = '0;
        if (access_wait && !PWRITE_IN) begin
            prdata_d = read_image(PADDR_IN, gates_q);
        end
    end

    // Register contents: writes land on the edge that completes the transfer
    always_comb begin
        gates_d = gates_q;
        if (write_done && (PADDR_IN == clock_gate_pkg::OFF_SERIAL_AND_BUS)) begin
            gates_d.serial_port  = PWDATA_IN[clock_gate_pkg::SERIAL_LSB +: clock_gate_pkg::SERIAL_W];
            gates_d.two_wire_bus = PWDATA_IN[clock_gate_pkg::TWO_WIRE_LSB +: clock_gate_pkg::TWO_WIRE_W];
        end
        if (write_done && (PADDR_IN == clock_gate_pkg::OFF_PORT_AND_TIMER)) begin
            gates_d.pin_port     = PWDATA_IN[clock_gate_pkg::PIN_PORT_LSB +: clock_gate_pkg::PIN_PORT_W];
            gates_d.timer_access = PWDATA_IN[clock_gate_pkg::TIMER_BIT];
        end
    end

    // Register the slave and the gate image
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            pready_q  <= 1'b0;
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
            gates_q   <= clock_gate_pkg::GATES_RESET;
        end else begin
            pready_q  <= pready_d;
            prdata_q  <= prdata_d;
            pslverr_q <= pslverr_d;
            gates_q   <= gates_d;
        end
    end

    assign PREADY_OUT  = pready_q;
    assign PRDATA_OUT  = prdata_q;
    assign PSLVERR_OUT = pslverr_q;

    ////////////////////////////////////////////////////////////////////////////
    // Gate enables to the peripherals
    // The gate cells sit beside each peripheral and hold their enable through the low
    // clock phase; this block only promises that every enable moves on a rising edge,
    // one cycle after the register image, and nowhere else.

    // One enable flop per gate, changing only on a clock edge
    clock_enable_cells #(
        .WIDTH (GW)
    ) u_enables (
        .clk_in     (CLK_IN),
        .reset_in   (RESET_IN),
        .enable_in  (gates_q),
        .enable_out (enables_out)
    );

    assign GATES_OUT = clock_gate_pkg::gates_t'(enables_out);

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (RESET_IN);

    // Request kinds decoded once for the checks below
    logic read_one;
    logic read_two;
    logic write_one;
    logic write_two;

    assign read_one  = access_wait && !PWRITE_IN && (PADDR_IN == clock_gate_pkg::OFF_SERIAL_AND_BUS);
    assign read_two  = access_wait && !PWRITE_IN && (PADDR_IN == clock_gate_pkg::OFF_PORT_AND_TIMER);
    assign write_one = write_done && (PADDR_IN == clock_gate_pkg::OFF_SERIAL_AND_BUS);
    assign write_two = write_done && (PADDR_IN == clock_gate_pkg::OFF_PORT_AND_TIMER);

    // Ready is a single-cycle answer one cycle after the wait
    a_ready_after_wait: assert property (
        access_wait |=> PREADY_OUT ##1 !PREADY_OUT
    ) else $error("Ready did not pulse once after the wait cycle");

    // Serial port enables follow a write to register one
    a_serial_write: assert property (
        (write_done && PADDR_IN == clock_gate_pkg::OFF_SERIAL_AND_BUS)
        |=> ##1 GATES_OUT.serial_port ==
            $past(PWDATA_IN[clock_gate_pkg::SERIAL_LSB +: clock_gate_pkg::SERIAL_W], 2)
    ) else $error("Serial port gates did not take the written bits");

    // Two-wire bus enables follow a write to register one
    a_two_wire_write: assert property (
        (write_done && PADDR_IN == clock_gate_pkg::OFF_SERIAL_AND_BUS)
        |=> ##1 GATES_OUT.two_wire_bus ==
            $past(PWDATA_IN[clock_gate_pkg::TWO_WIRE_LSB +: clock_gate_pkg::TWO_WIRE_W], 2)
    ) else $error("Two-wire bus gates did not take the written bits");

    // Pin port enables follow a write to register two
    a_pin_port_write: assert property (
        (write_done && PADDR_IN == clock_gate_pkg::OFF_PORT_AND_TIMER)
        |=> ##1 GATES_OUT.pin_port ==
            $past(PWDATA_IN[clock_gate_pkg::PIN_PORT_LSB +: clock_gate_pkg::PIN_PORT_W], 2)
    ) else $error("Pin port gates did not take the written bits");

    // Timer access follows bit 0 of register two
    a_timer_access: assert property (
        (write_done && PADDR_IN == clock_gate_pkg::OFF_PORT_AND_TIMER)
        |=> ##1 GATES_OUT.timer_access ==
            $past(PWDATA_IN[clock_gate_pkg::TIMER_BIT], 2)
    ) else $error("Timer access did not take bit 0");

    // Reserved one-fields of register one read as ones whatever was written
    a_reserved_ones: assert property (
        (access_wait && !PWRITE_IN && PADDR_IN == clock_gate_pkg::OFF_SERIAL_AND_BUS)
        |=> PRDATA_OUT[5:4] == 2'b11 && PRDATA_OUT[9:8] == 2'b00
    ) else $error("Reserved bits of register one read wrong");

    // Reserved zero-fields of register two read as zero
    a_reserved_zero: assert property (
        (access_wait && !PWRITE_IN && PADDR_IN == clock_gate_pkg::OFF_PORT_AND_TIMER)
        |=> PRDATA_OUT[31:14] == '0 && PRDATA_OUT[6:1] == '0 && PRDATA_OUT[8:7] == 2'b11
    ) else $error("Reserved bits of register two read wrong");

    // Enables never move without a completed write two cycles earlier
    a_gate_stable: assert property (
        !$past(write_done, 2) |-> $stable(GATES_OUT)
    ) else $error("Gate enable moved without a write");

    // Register two reads back exactly what the pin port and timer gates carry
    a_read_image: assert property (
        read_two
        |=> PRDATA_OUT[clock_gate_pkg::PIN_PORT_LSB +: clock_gate_pkg::PIN_PORT_W] == GATES_OUT.pin_port &&
            PRDATA_OUT[clock_gate_pkg::TIMER_BIT] == GATES_OUT.timer_access
    ) else $error("Read data of register two does not match the gates");

    // Register one reads back exactly what the serial and two-wire gates carry
    a_read_one_fields: assert property (
        read_one
        |=> PRDATA_OUT[clock_gate_pkg::SERIAL_LSB +: clock_gate_pkg::SERIAL_W] == GATES_OUT.serial_port &&
            PRDATA_OUT[clock_gate_pkg::TWO_WIRE_LSB +: clock_gate_pkg::TWO_WIRE_W] == GATES_OUT.two_wire_bus
    ) else $error("Read data of register one does not match the gates");

    // Unmapped addresses answer with an error and empty data
    a_error_unmapped: assert property (
        (access_wait && !is_mapped(PADDR_IN))
        |=> PSLVERR_OUT && PRDATA_OUT == '0
    ) else $error("Unmapped access was not refused");

    // Mapped addresses never raise the error
    a_mapped_no_error: assert property (
        (access_wait && is_mapped(PADDR_IN))
        |=> !PSLVERR_OUT
    ) else $error("Mapped access answered with an error");

    // Write answers carry no read data
    a_write_no_data: assert property (
        (access_wait && PWRITE_IN)
        |=> PRDATA_OUT == '0
    ) else $error("Write answer carried read data");

    // Data and error stay low outside the ready cycle
    a_quiet_idle: assert property (
        !PREADY_OUT
        |-> !PSLVERR_OUT && PRDATA_OUT == '0
    ) else $error("Data or error shown without ready");

    // Ready only answers a waiting access
    a_ready_needs_wait: assert property (
        PREADY_OUT
        |-> $past(access_wait)
    ) else $error("Ready raised without a waiting access");

    // A refused write leaves every gate as it was
    a_refused_write: assert property (
        (access_done && PWRITE_IN && PSLVERR_OUT)
        |=> $stable(gates_q)
    ) else $error("Refused write changed a gate");

    // Serial port enables move only on a write to register one
    a_serial_hold: assert property (
        !write_one
        |=> $stable(gates_q.serial_port)
    ) else $error("Serial port gates moved without a write");

    // Two-wire bus enables move only on a write to register one
    a_two_wire_hold: assert property (
        !write_one
        |=> $stable(gates_q.two_wire_bus)
    ) else $error("Two-wire bus gates moved without a write");

    // Pin port enables move only on a write to register two
    a_pin_port_hold: assert property (
        !write_two
        |=> $stable(gates_q.pin_port)
    ) else $error("Pin port gates moved without a write");

    // Timer access moves only on a write to register two
    a_timer_hold: assert property (
        !write_two
        |=> $stable(gates_q.timer_access)
    ) else $error("Timer access moved without a write");

    // Leaving reset, every gate is closed and the timer locked
    a_reset_closed: assert property (
        $fell(RESET_IN)
        |-> GATES_OUT == clock_gate_pkg::GATES_RESET
    ) else $error("Gates not closed after reset");

    // Leaving reset, the bus answer is quiet
    a_reset_quiet: assert property (
        $fell(RESET_IN)
        |-> !PREADY_OUT && !PSLVERR_OUT && PRDATA_OUT == '0
    ) else $error("Bus answer shown after reset");

    // Gate outputs follow the register image one edge later
    a_gates_follow: assert property (
        1'b1
        |-> GATES_OUT == $past(gates_q)
    ) else $error("Gate outputs do not follow the register image");

    // Main scenarios
    c_write_serial: cover property (write_done && PADDR_IN == clock_gate_pkg::OFF_SERIAL_AND_BUS);
    c_write_ports: cover property (write_done && PADDR_IN == clock_gate_pkg::OFF_PORT_AND_TIMER);
    c_unmapped: cover property (PREADY_OUT && PSLVERR_OUT);
    c_gate_close: cover property ($fell(GATES_OUT.pin_port[0]));
    c_timer_open: cover property ($rose(GATES_OUT.timer_access));

endmodule

// ### tb_peripheral_clock_gate_bank.sv
// Self-checking testbench for the peripheral clock gate bank over APB
`timescale 1ns/1ps

module tb_peripheral_clock_gate_bank;
    logic                   CLK_IN;
    logic                   RESET_IN;
    logic                   PSEL_IN;
    logic                   PENABLE_IN;
    logic                   PWRITE_IN;
    logic [11:0]            PADDR_IN;
    logic [31:0]            PWDATA_IN;
    logic                   PREADY_OUT;
    logic [31:0]            PRDATA_OUT;
    logic                   PSLVERR_OUT;
    clock_gate_pkg::gates_t GATES_OUT;
    int                     n_fail;
    int                     total_checks;
    int                     cycles;
    logic [31:0]            rd;
    logic                   err;
    logic [31:0]            v;

    peripheral_clock_gate_bank DUT (
        .CLK_IN      (CLK_IN),
        .RESET_IN    (RESET_IN),
        .PSEL_IN     (PSEL_IN),
        .PENABLE_IN  (PENABLE_IN),
        .PWRITE_IN   (PWRITE_IN),
        .PADDR_IN    (PADDR_IN),
        .PWDATA_IN   (PWDATA_IN),
        .PREADY_OUT  (PREADY_OUT),
        .PRDATA_OUT  (PRDATA_OUT),
        .PSLVERR_OUT (PSLVERR_OUT),
        .GATES_OUT   (GATES_OUT)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, time-zero values and hang guard
    initial begin
        CLK_IN       = 1'b0;
        RESET_IN     = 1'b1;
        PSEL_IN      = 1'b0;
        PENABLE_IN   = 1'b0;
        PWRITE_IN    = 1'b0;
        PADDR_IN     = 12'h000;
        PWDATA_IN    = 32'h0000_0000;
        n_fail       = 0;
        total_checks = 0;
        cycles       = 0;
    end
    always #2.5 CLK_IN = ~CLK_IN;

    // Cuts the run short if a transfer never completes
    always @(posedge CLK_IN) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            $display("Error at %0t: run exceeded cycle ceiling", $time);
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One APB transfer: setup, access until ready, release after the ready edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge CLK_IN);
        PSEL_IN    <= 1'b1;
        PENABLE_IN <= 1'b0;
        PWRITE_IN  <= wr;
        PADDR_IN   <= a;
        PWDATA_IN  <= wd;
        @(posedge CLK_IN);
        PENABLE_IN <= 1'b1;
        // Wait for the rising edge that samples ready high; only the cycle ceiling ends a hang
        do begin
            @(posedge CLK_IN);
        end while (PREADY_OUT !== 1'b1);
        rd  = PRDATA_OUT;
        err = PSLVERR_OUT;
        PSEL_IN    <= 1'b0;
        PENABLE_IN <= 1'b0;
    endtask

    // Compares and counts
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Gate outputs expected from the two register images, once they have settled
    task automatic check_gates(input logic [31:0] r0, input logic [31:0] r1);
        clock_gate_pkg::gates_t g;
        g.serial_port  = r0[12:10];
        g.two_wire_bus = r0[7:6];
        g.pin_port     = r1[13:9];
        g.timer_access = r1[0];
        repeat (2) @(posedge CLK_IN);
        @(negedge CLK_IN);
        check(32'(GATES_OUT), 32'(g), "gate enables");
    endtask

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial begin
        repeat (16) @(posedge CLK_IN);
        RESET_IN <= 1'b0;
        apb(1'b0, 12'h000, 32'h0000_0000);
        check(rd, 32'h0000_0030, "reg0 reset");
        check(32'(err), 32'h0, "reg0 error");
        apb(1'b0, 12'h004, 32'h0000_0000);
        check(rd, 32'h0000_0180, "reg1 reset");
        check_gates(32'h0, 32'h0);
        $display("Test reset values done");
        // Single set bit and single clear bit walked over both registers
        for (int i = 0; i < 32; i++) begin
            for (int k = 0; k < 2; k++) begin
                v = (k == 0) ? (32'h1 << i) : ~(32'h1 << i);
                apb(1'b1, 12'h000, v);
                apb(1'b1, 12'h004, v);
                apb(1'b0, 12'h000, 32'h0);
                check(rd, 32'h0000_0030 | (v & 32'h0000_1cc0), "reg0 image");
                apb(1'b0, 12'h004, 32'h0);
                check(rd, 32'h0000_0180 | (v & 32'h0000_3e01), "reg1 image");
                check_gates(v, v);
            end
        end
        $display("Test walking bits done");
        // Unmapped address refused, registers untouched
        apb(1'b1, 12'h000, 32'hffff_ffff);
        apb(1'b1, 12'h008, 32'h0000_0000);
        check(32'(err), 32'h1, "unmapped write error");
        apb(1'b0, 12'h008, 32'h0);
        check(rd, 32'h0, "unmapped read data");
        check(32'(err), 32'h1, "unmapped read error");
        apb(1'b0, 12'h000, 32'h0);
        check(rd, 32'h0000_1cf0, "reg0 after refusal");
        check_gates(32'hffff_ffff, v);
        $display("Test unmapped access done");
        end_of_test();
    end
endmodule
